// file: core/rcm_pkg.sv
package rcm_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_DBSIZE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_NOREAD = 8'h10;
  localparam logic [7:0] OFF_TRIG = 8'h14;
  localparam logic [7:0] OFF_GOOD = 8'h18;
  localparam logic [7:0] OFF_MISM = 8'h1C;
  localparam logic [7:0] OFF_RATE = 8'h20;
  localparam logic [7:0] OFF_LIMIT = 8'h24;
  localparam logic [7:0] OFF_PN_BOOT = 8'h28;
  localparam logic [7:0] OFF_PN_APP = 8'h2C;
  localparam logic [7:0] OFF_PN_PROF = 8'h30;
  localparam logic [7:0] OFF_CK_BOOT = 8'h34;
  localparam logic [7:0] OFF_CK_APP = 8'h38;
  localparam logic [7:0] OFF_CK_PROF = 8'h3C;
  localparam logic [7:0] OFF_WDATA = 8'h40;
  localparam logic [1:0] REGION_ENT_LEN = 2'h2;
  localparam logic [1:0] REGION_ENT_DATA = 2'h3;

  // ==========================================================================
  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_LEN_LSB = 16;
  localparam int CTRL_MATCH_EN = 0;
  localparam int ST_ENABLED = 0;
  localparam int ST_DPS = 1;
  localparam int ST_PCT = 2;
  localparam int ST_ERR = 3;
  localparam int ST_PEND_LSB = 8;
  localparam int ENT_IDX_LSB = 16;

  // ==========================================================================
  // Sizes and reset values
  localparam int IDX_W = 4;
  localparam int LEN_W = 12;
  localparam int MAX_ENTRIES = 10;
  localparam logic [3:0] DB_SIZE_RST = 4'h1;
  localparam logic [3:0] DB_SIZE_MIN = 4'h1;
  localparam logic [3:0] DB_SIZE_MAX = 4'hA;
  localparam logic CTRL_RST = 1'b0;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_NS = 10000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_KHZ) / 1000000;
  localparam int RATE_WIN_MS = 1000;

  // ==========================================================================
  // Command opcodes
  typedef enum logic [7:0] {
    OP_NOP = 8'h00,
    OP_DPS_TEST = 8'h01,
    OP_PCT_TEST = 8'h02,
    OP_RATE_EXIT = 8'h03,
    OP_NOREAD_CLR = 8'h04,
    OP_TRIG_CLR = 8'h05,
    OP_GOOD_CLR = 8'h06,
    OP_MISM_CLR = 8'h07,
    OP_PULSE1 = 8'h08,
    OP_PULSE2 = 8'h09,
    OP_PULSE3 = 8'h0A,
    OP_DISABLE = 8'h0B,
    OP_ENABLE = 8'h0C,
    OP_MASTER_SET = 8'h0D,
    OP_CAPTURE = 8'h0E
  } rcm_op_t;

  // Per-entry character limit for a database size (pool of 3000 split evenly)
  function automatic logic [11:0] rcm_limit(input logic [3:0] size);
    case (size)
      4'h1: rcm_limit = 12'd3000;
      4'h2: rcm_limit = 12'd1500;
      4'h3: rcm_limit = 12'd1000;
      4'h4: rcm_limit = 12'd750;
      4'h5: rcm_limit = 12'd600;
      4'h6: rcm_limit = 12'd500;
      4'h7: rcm_limit = 12'd428;
      4'h8: rcm_limit = 12'd375;
      4'h9: rcm_limit = 12'd333;
      4'hA: rcm_limit = 12'd300;
      default: rcm_limit = 12'h000;
    endcase
  endfunction : rcm_limit

endpackage : rcm_pkg

// file: core/rcm_evt_counter.sv
`timescale 1ns/1ps
module rcm_evt_counter #(
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic inc,
  input wire logic clr,
  output logic [CNT_W-1:0] count
);

  // ==========================================================================
  // Saturating counter; an event in the clear cycle counts as one
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (clr) begin
        cnt_ff <= inc ? CNT_W'(1) : '0;
      end else if (inc && (cnt_ff != '1)) begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  assign count = cnt_ff;

endmodule : rcm_evt_counter

// file: core/rcm_pulse_gen.sv
`timescale 1ns/1ps
module rcm_pulse_gen #(
  parameter int LEN = 1250
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic fire,
  output logic pulse
);

  // ==========================================================================
  // Holds the output high for LEN cycles; a new fire restarts the span
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] left_ff;
  logic pulse_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= '0;
      pulse_ff <= 1'b0;
    end else if (ce) begin
      if (fire) begin
        left_ff <= CW'(LEN - 1);
        pulse_ff <= 1'b1;
      end else if (left_ff != '0) begin
        left_ff <= left_ff - CW'(1);
      end else begin
        pulse_ff <= 1'b0;
      end
    end
  end

  assign pulse = pulse_ff;

endmodule : rcm_pulse_gen

// file: core/rcm_reader_cmd.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module rcm_reader_cmd
  import rcm_pkg::*;
#(
  parameter int unsigned RATE_WIN_CYC = RATE_WIN_MS * CLK_KHZ,
  parameter int CNT_W = 32,
  parameter logic [31:0] PN_BOOT = 32'h0000_0B01,  // Arbitrary value
  parameter logic [31:0] PN_APP = 32'h0000_0A01,   // Arbitrary value
  parameter logic [31:0] PN_PROF = 32'h0000_0C01,  // Arbitrary value
  parameter logic [31:0] CK_BOOT = 32'h0000_1111,  // Arbitrary value
  parameter logic [31:0] CK_APP = 32'h0000_2222,   // Arbitrary value
  parameter logic [31:0] CK_PROF = 32'h0000_3333   // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_evt,
  input wire logic noread_evt,
  input wire logic decode_evt,
  input wire logic [11:0] decode_len,
  input wire logic [31:0] decode_word,
  output logic reader_enabled,
  output logic read_abort,
  output logic [2:0] out_pulse,
  output logic dps_test_active,
  output logic pct_test_active,
  output logic rate_strobe,
  output logic [31:0] rate_value
);

  // ==========================================================================
  // Bus slave state
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_fire, wr_ok;
  logic [31:0] rd_mux;
  logic rd_ok;

  // ==========================================================================
  // Block state
  logic en_ff, abort_ff, dps_ff, pct_ff, err_ff, match_en_ff;
  logic [3:0] size_ff, pend_ff;
  logic [31:0] wdata_ff;
  logic [11:0] limit;
  logic [11:0] ent_len [1:MAX_ENTRIES];
  logic [31:0] ent_data [1:MAX_ENTRIES];
  logic [MAX_ENTRIES:1] hit;
  logic match;
  logic [3:0] cnt_inc, cnt_clr;
  logic [CNT_W-1:0] cnt_val [0:3];
  logic [2:0] pulse_fire;

  // ==========================================================================
  // Command decode
  logic cmd_go, size_go, bad_cmd, ent_go, cap_cmd, cap_go, cap_fit;
  logic trig_ok, noread_ok, dec_ok;
  rcm_op_t cmd_op;
  logic [3:0] cmd_idx, cap_idx, new_size;
  logic [11:0] cmd_len;

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;

  // Writable map; partial strobes are refused
  always_comb begin
    case (aw_addr_ff)
      OFF_CMD, OFF_CTRL, OFF_DBSIZE, OFF_STATUS, OFF_WDATA: wr_ok = (w_strb_ff == 4'hF);
      default: wr_ok = 1'b0;
    endcase
  end

  // Write address/data capture in either order, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd_mux[CTRL_MATCH_EN] = match_en_ff;
      OFF_DBSIZE: rd_mux[3:0] = size_ff;
      OFF_STATUS: begin
        rd_mux[ST_ENABLED] = en_ff;
        rd_mux[ST_DPS] = dps_ff;
        rd_mux[ST_PCT] = pct_ff;
        rd_mux[ST_ERR] = err_ff;
        rd_mux[ST_PEND_LSB +: IDX_W] = pend_ff;
      end
      OFF_NOREAD: rd_mux = 32'(cnt_val[0]);
      OFF_TRIG: rd_mux = 32'(cnt_val[1]);
      OFF_GOOD: rd_mux = 32'(cnt_val[2]);
      OFF_MISM: rd_mux = 32'(cnt_val[3]);
      OFF_RATE: rd_mux = rate_value;
      OFF_LIMIT: rd_mux[LEN_W-1:0] = limit;
      OFF_PN_BOOT: rd_mux = PN_BOOT;
      OFF_PN_APP: rd_mux = PN_APP;
      OFF_PN_PROF: rd_mux = PN_PROF;
      OFF_CK_BOOT: rd_mux = CK_BOOT;
      OFF_CK_APP: rd_mux = CK_APP;
      OFF_CK_PROF: rd_mux = CK_PROF;
      OFF_WDATA: rd_mux = wdata_ff;
      default: begin
        if (s_axi_araddr[7:6] == REGION_ENT_LEN && s_axi_araddr[5:2] == 4'h0) begin
          rd_mux[3:0] = size_ff;
        end else if (s_axi_araddr[5:2] >= 4'h1 && s_axi_araddr[5:2] <= DB_SIZE_MAX &&
                     s_axi_araddr[7] && s_axi_araddr[1:0] == 2'h0) begin
          if (s_axi_araddr[5:2] <= size_ff) begin
            if (s_axi_araddr[7:6] == REGION_ENT_LEN) begin
              rd_mux[ENT_IDX_LSB +: IDX_W] = s_axi_araddr[5:2];
              rd_mux[LEN_W-1:0] = ent_len[s_axi_araddr[5:2]];
            end else begin
              rd_mux = ent_data[s_axi_araddr[5:2]];
            end
          end
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Command fields and strobes
  assign cmd_go = wr_fire & wr_ok & (aw_addr_ff == OFF_CMD);
  assign cmd_op = rcm_op_t'(w_data_ff[CMD_OP_LSB +: 8]);
  assign cmd_idx = w_data_ff[CMD_IDX_LSB +: IDX_W];
  assign cmd_len = w_data_ff[CMD_LEN_LSB +: LEN_W];
  assign new_size = w_data_ff[3:0];
  assign size_go = wr_fire & wr_ok & (aw_addr_ff == OFF_DBSIZE) &
                   (new_size >= DB_SIZE_MIN) & (new_size <= DB_SIZE_MAX);
  assign limit = rcm_limit(size_ff);
  assign ent_go = cmd_go & (cmd_op == OP_MASTER_SET) & (cmd_idx >= 4'h1) &
                  (cmd_idx <= size_ff) & (cmd_len <= limit);
  assign cap_idx = (cmd_idx == 4'h0) ? 4'h1 : cmd_idx;
  assign cap_cmd = cmd_go & (cmd_op == OP_CAPTURE) & (cap_idx <= size_ff);
  assign trig_ok = trigger_evt & en_ff;
  assign noread_ok = noread_evt & en_ff;
  assign dec_ok = decode_evt & en_ff;
  assign cap_go = dec_ok & (pend_ff != 4'h0);
  assign cap_fit = (decode_len <= limit) & (decode_len != 12'h000);

  // Malformed commands and sizes, and captured decodes that do not fit
  always_comb begin
    bad_cmd = 1'b0;
    if (wr_fire && wr_ok && aw_addr_ff == OFF_DBSIZE && !size_go) begin
      bad_cmd = 1'b1;
    end
    if (cmd_go && cmd_op == OP_MASTER_SET && !ent_go) begin
      bad_cmd = 1'b1;
    end
    if (cmd_go && cmd_op == OP_CAPTURE && !cap_cmd) begin
      bad_cmd = 1'b1;
    end
    if (cap_go && !cap_fit) begin
      bad_cmd = 1'b1;
    end
  end

  // Configuration registers; reader enable does not touch them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_en_ff <= CTRL_RST;
      size_ff <= DB_SIZE_RST;
      wdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_fire && wr_ok && aw_addr_ff == OFF_CTRL) begin
        match_en_ff <= w_data_ff[CTRL_MATCH_EN];
      end
      if (size_go) begin
        size_ff <= new_size;
      end
      if (wr_fire && wr_ok && aw_addr_ff == OFF_WDATA) begin
        wdata_ff <= w_data_ff;
      end
    end
  end

  // Reader on/off and read-cycle abort
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff <= 1'b1;
      abort_ff <= 1'b0;
    end else if (ce) begin
      abort_ff <= cmd_go && cmd_op == OP_DISABLE && en_ff;
      if (cmd_go && cmd_op == OP_DISABLE) begin
        en_ff <= 1'b0;
      end else if (cmd_go && cmd_op == OP_ENABLE) begin
        en_ff <= 1'b1;
      end
    end
  end

  // Read-rate test modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dps_ff <= 1'b0;
      pct_ff <= 1'b0;
    end else if (ce && cmd_go) begin
      case (cmd_op)
        OP_DPS_TEST: begin
          dps_ff <= 1'b1;
          pct_ff <= 1'b0;
        end
        OP_PCT_TEST: begin
          pct_ff <= 1'b1;
          dps_ff <= 1'b0;
        end
        OP_RATE_EXIT: begin
          dps_ff <= 1'b0;
          pct_ff <= 1'b0;
        end
        default: begin
          dps_ff <= dps_ff;
        end
      endcase
    end
  end

  // Rate window: decodes per window, or triggers and good reads in pct mode
  logic [31:0] win_ff, win_dec_ff, win_trig_ff, win_good_ff;
  logic win_end, test_start;
  logic [31:0] rate_ff;
  logic rate_stb_ff;
  assign win_end = (win_ff == RATE_WIN_CYC - 1);
  assign test_start = cmd_go & ((cmd_op == OP_DPS_TEST) | (cmd_op == OP_PCT_TEST));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_ff <= 32'h0000_0000;
      win_dec_ff <= 32'h0000_0000;
      win_trig_ff <= 32'h0000_0000;
      win_good_ff <= 32'h0000_0000;
      rate_ff <= 32'h0000_0000;
      rate_stb_ff <= 1'b0;
    end else if (ce) begin
      rate_stb_ff <= 1'b0;
      if (test_start || !(dps_ff || pct_ff)) begin
        win_ff <= 32'h0000_0000;
        win_dec_ff <= 32'h0000_0000;
        win_trig_ff <= 32'h0000_0000;
        win_good_ff <= 32'h0000_0000;
      end else if (win_end) begin
        win_ff <= 32'h0000_0000;
        win_dec_ff <= 32'h0000_0000;
        win_trig_ff <= 32'h0000_0000;
        win_good_ff <= 32'h0000_0000;
        rate_stb_ff <= 1'b1;
        rate_ff <= dps_ff ? win_dec_ff + 32'(dec_ok)
                          : {win_trig_ff[15:0], win_good_ff[15:0]};
      end else begin
        win_ff <= win_ff + 32'h0000_0001;
        win_dec_ff <= win_dec_ff + 32'(dec_ok);
        win_trig_ff <= win_trig_ff + 32'(trig_ok);
        win_good_ff <= win_good_ff + 32'(cnt_inc[2]);
      end
    end
  end

  // Pending capture index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= 4'h0;
    end else if (ce) begin
      if (cap_cmd) begin
        pend_ff <= cap_idx;
      end else if (cap_go) begin
        pend_ff <= 4'h0;
      end
    end
  end

  // Sticky command error; a new error beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_ff <= 1'b0;
    end else if (ce) begin
      if (bad_cmd) begin
        err_ff <= 1'b1;
      end else if (wr_fire && wr_ok && aw_addr_ff == OFF_STATUS && w_data_ff[ST_ERR]) begin
        err_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Master database entries and match
  genvar gi;
  generate
    for (gi = 1; gi <= MAX_ENTRIES; gi++) begin : g_ent
      localparam logic [3:0] IDX = 4'(gi);
      logic [11:0] len_ff;
      logic [31:0] data_ff;

      // Capture, then host entry, then pruning on size change
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          len_ff <= 12'h000;
          data_ff <= 32'h0000_0000;
        end else if (ce) begin
          if (cap_go && cap_fit && pend_ff == IDX) begin
            len_ff <= decode_len;
            data_ff <= decode_word;
          end
          if (ent_go && cmd_idx == IDX) begin
            len_ff <= cmd_len;
            data_ff <= (cmd_len == 12'h000) ? 32'h0000_0000 : wdata_ff;
          end
          if (size_go && len_ff > rcm_limit(new_size)) begin
            len_ff <= 12'h000;
            data_ff <= 32'h0000_0000;
          end
        end
      end

      assign ent_len[gi] = len_ff;
      assign ent_data[gi] = data_ff;
      assign hit[gi] = (IDX <= size_ff) && (len_ff != 12'h000) &&
                       (len_ff == decode_len) && (data_ff == decode_word);
    end
  endgenerate
  assign match = |hit;

  // ==========================================================================
  // Counters: no-read, trigger, good/match, mismatch
  assign cnt_inc[0] = noread_ok;
  assign cnt_inc[1] = trig_ok;
  assign cnt_inc[2] = dec_ok & (~match_en_ff | match);
  assign cnt_inc[3] = dec_ok & match_en_ff & ~match;
  assign cnt_clr[0] = cmd_go & (cmd_op == OP_NOREAD_CLR);
  assign cnt_clr[1] = cmd_go & (cmd_op == OP_TRIG_CLR);
  assign cnt_clr[2] = cmd_go & (cmd_op == OP_GOOD_CLR);
  assign cnt_clr[3] = cmd_go & (cmd_op == OP_MISM_CLR);

  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      rcm_evt_counter #(.CNT_W(CNT_W)) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .inc(cnt_inc[gi]),
        .clr(cnt_clr[gi]),
        .count(cnt_val[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Output pulses, independent of matching and output configuration
  assign pulse_fire[0] = cmd_go & (cmd_op == OP_PULSE1);
  assign pulse_fire[1] = cmd_go & (cmd_op == OP_PULSE2);
  assign pulse_fire[2] = cmd_go & (cmd_op == OP_PULSE3);

  generate
    for (gi = 0; gi < 3; gi++) begin : g_pulse
      rcm_pulse_gen #(.LEN(PULSE_CYC)) u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .fire(pulse_fire[gi]),
        .pulse(out_pulse[gi])
      );
    end
  endgenerate

  // Status outputs
  assign reader_enabled = en_ff;
  assign read_abort = abort_ff;
  assign dps_test_active = dps_ff;
  assign pct_test_active = pct_ff;
  assign rate_strobe = rate_stb_ff;
  assign rate_value = rate_ff;

endmodule : rcm_reader_cmd

// file: tb/rcm_reader_cmd_props.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks
module rcm_reader_cmd_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic reader_enabled,
  input wire logic read_abort,
  input wire logic [2:0] out_pulse,
  input wire logic dps_test_active,
  input wire logic pct_test_active,
  input wire logic rate_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && ce |=> ##1 s_axi_bvalid) else $error("write response missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read response missing");
  pulse_hold_a: assert property ($rose(|out_pulse) |-> (|out_pulse)[*8])
    else $error("output pulse too short");
  abort_off_a: assert property (read_abort |-> !reader_enabled)
    else $error("abort while reader on");
  abort_once_a: assert property (read_abort |=> !read_abort)
    else $error("abort longer than one cycle");
  disable_abort_a: assert property ($fell(reader_enabled) |-> read_abort)
    else $error("disable without abort");
  one_test_a: assert property (!(dps_test_active && pct_test_active))
    else $error("both rate tests active");
  rate_src_a: assert property (rate_strobe |-> $past(dps_test_active || pct_test_active))
    else $error("rate report without a test");
endmodule : rcm_reader_cmd_props

bind rcm_reader_cmd rcm_reader_cmd_props chk_u (.aclk, .aresetn, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .reader_enabled, .read_abort, .out_pulse, .dps_test_active, .pct_test_active,
  .rate_strobe);

// file: tb/rcm_reader_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Reader front end: one-cycle events
module rcm_reader_model (
  input wire logic aclk,
  output logic trigger_evt = 1'h0,
  output logic noread_evt = 1'h0,
  output logic decode_evt = 1'h0,
  output logic [11:0] decode_len = 12'h000,
  output logic [31:0] decode_word = 32'h0
);
  // Kind 0 trigger, 1 no-read, 2 decode; symbol lines inverted once released
  task ev(input int k, input logic [11:0] l = 12'h005, input logic [31:0] w = 32'h1234);
    @(posedge aclk);
    {trigger_evt, noread_evt, decode_evt} <= {k == 0, k == 1, k == 2};
    {decode_len, decode_word} <= {l, w};
    @(posedge aclk);
    {trigger_evt, noread_evt, decode_evt} <= 3'h0;
    {decode_len, decode_word} <= {~l, ~w};
  endtask : ev
endmodule : rcm_reader_model

// file: tb/rcm_reader_cmd_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench
module rcm_reader_cmd_tb;
  import rcm_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rate_value, decode_word, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, decode_evt;
  logic reader_enabled, read_abort, dps_test_active, pct_test_active, rate_strobe;
  logic trigger_evt, noread_evt;
  logic [2:0] out_pulse;
  logic [11:0] decode_len;
  int errors = 0, num_checks = 0;
  always #4 aclk = ~aclk;
  rcm_reader_cmd #(.RATE_WIN_CYC(20), .PN_APP(32'h0000_0A5A), .CK_PROF(32'h0000_5A5A)) dut_u (.*);
  rcm_reader_model rdr_u (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    {ta, tw} = 2'h0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    while (!(ta && tw)) begin
      @(negedge aclk);
      {ta, tw} = {ta | s_axi_awready, tw | s_axi_wready};
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid} <= {!ta, !tw};
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, d);
  endtask : rchk
  task cmd(input logic [7:0] op, input logic [3:0] idx);
    wr(OFF_CMD, {20'h0, idx, op});
    @(negedge aclk);
  endtask : cmd
  task t_count;
    repeat (3) rdr_u.ev(0);
    rdr_u.ev(1);
    rchk(OFF_TRIG, 32'h3, "trig");
    rchk(OFF_NOREAD, 32'h1, "noread");
    rdr_u.ev(2);
    wr(OFF_CTRL, 32'h1);
    rdr_u.ev(2);
    rdr_u.ev(2, 12'h005, 32'h5678);
    rchk(OFF_GOOD, 32'h3, "good");
    rchk(OFF_MISM, 32'h1, "mismatch");
    for (int i = 4; i < 8; i++) cmd(8'(i), 4'h0);
    for (int i = 0; i < 4; i++) rchk(8'h10 + 8'(4 * i), 32'h0, "clear");
  endtask : t_count
  task t_pulse;
    for (int i = 0; i < 3; i++) begin
      cmd(8'h08 + 8'(i), 4'h0);
      chk("pulse", 32'(3'h1 << i), 32'(out_pulse));
      repeat (PULSE_CYC + 50) @(posedge aclk);
      chk("pulse end", 32'h0, 32'(out_pulse));
    end
  endtask : t_pulse
  task t_enable;
    cmd(8'h0B, 4'h0);
    chk("enabled", 32'h0, 32'(reader_enabled));
    rdr_u.ev(0);
    rchk(OFF_TRIG, 32'h0, "trig off");
    rchk(OFF_CTRL, 32'h1, "ctrl kept");
    cmd(8'h0C, 4'h0);
    rdr_u.ev(0);
    rchk(OFF_TRIG, 32'h1, "trig on");
    // Clock enable low: a trigger must leave no trace
    @(posedge aclk);
    ce <= 1'h0;
    rdr_u.ev(0);
    @(posedge aclk);
    ce <= 1'h1;
    rchk(OFF_TRIG, 32'h1, "trig frozen");
  endtask : t_enable
  task t_db;
    rchk(OFF_DBSIZE, 32'h1, "size");
    rchk(OFF_LIMIT, 32'hBB8, "limit");
    rchk(OFF_PN_APP, 32'h0000_0A5A, "part number");
    rchk(OFF_CK_PROF, 32'h0000_5A5A, "checksum");
    s_axi_wstrb <= 4'h1;
    wr(OFF_CTRL, 32'h1);
    s_axi_wstrb <= 4'hF;
    chk("strobe resp", 32'(RESP_SLVERR), 32'(r));
    rchk(OFF_CTRL, 32'h0, "ctrl refused");
    wr(OFF_CMD, 32'h07D0_010D);
    rchk(8'h84, 32'h1_07D0, "long entry");
    wr(OFF_DBSIZE, 32'hA);
    rchk(OFF_LIMIT, 32'h12C, "limit");
    rchk(8'h84, 32'h1_0000, "pruned");
    wr(OFF_DBSIZE, 32'hB);
    chk("size resp", 32'(RESP_OKAY), 32'(r));
    rchk(OFF_DBSIZE, 32'hA, "size");
    rchk(OFF_STATUS, 32'h9, "size error");
    wr(OFF_STATUS, 32'h8);
    rd(8'h44);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    cmd(8'h0E, 4'h0);
    rchk(OFF_STATUS, 32'h101, "pending");
    rdr_u.ev(2);
    rchk(OFF_STATUS, 32'h1, "loaded");
    rchk(8'h84, 32'h1_0005, "entry one");
    rchk(8'h80, 32'hA, "entry count");
    wr(OFF_WDATA, 32'hCAFE);
    wr(OFF_CMD, 32'h0003_020D);
    rchk(8'hC8, 32'hCAFE, "entry data");
    wr(OFF_CMD, 32'h012D_030D);
    rchk(8'h8C, 32'h3_0000, "entry too long");
    wr(OFF_DBSIZE, 32'h1);
    rchk(8'h88, 32'h0, "entry hidden");
    wr(OFF_DBSIZE, 32'h2);
    wr(OFF_CMD, 32'h0000_020D);
    rchk(8'h88, 32'h2_0000, "entry deleted");
  endtask : t_db
  task t_rate;
    cmd(8'h01, 4'h0);
    chk("dps", 32'h1, 32'(dps_test_active));
    do @(negedge aclk); while (!rate_strobe);
    repeat (2) rdr_u.ev(2);
    do @(negedge aclk); while (!rate_strobe);
    chk("rate", 32'h2, rate_value);
    cmd(8'h02, 4'h0);
    chk("tests", 32'h1, 32'({dps_test_active, pct_test_active}));
    cmd(8'h03, 4'h0);
    chk("tests", 32'h0, 32'({dps_test_active, pct_test_active}));
  endtask : t_rate
  task end_sim;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_db();
    t_count();
    t_enable();
    t_pulse();
    t_rate();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_sim();
  end
endmodule : rcm_reader_cmd_tb
